/* File: ufc_pkg.sv */
// Package: constants and carriers for the UART flow and trigger configuration block
// Contract
// R1: CTS flow enable set stops transmit while CTS pin is high; clear ignores CTS.
// R2: RTS flow enable drives RTS high at halt fill, low again at resume fill.
// R3: Special detect compares each received char with second stop char; match sets flag.
// R4: Feature bit 4 clear blocks writes to interrupt 7:4, FIFO 5:4, modem 7:5.
// R5: Feature low nibble selects software flow control combination.
// R6: Two byte latches form a 16-bit baud divisor, high latch is MSB.
// R7: Divisor writes only take effect while sleep mode bit is clear.
// R8: Threshold upper nibble is resume level, lower is halt level, steps of four.
// R9: Threshold register writable only with feature bit 4 and modem bit 6 set.
// R10: Host programs halt above resume before enabling flow control; no hardware check.
// R11: Trigger upper nibble is receive level, lower is transmit level, level over four.
// R12: Trigger register writable only with feature bit 4 and modem bit 6 set.
// R13: A zero trigger nibble falls back to the FIFO control selected level.
// R14: Ready upper bits: receive fill above trigger or receive time-out.
// R15: Ready lower bits: transmit free space at least the transmit trigger.
// R16: Ready register at address 7 with any select low, modem bit 2, no loop-back.
// R17: Host reaches feature register at offset 2 with line control 0xbf.
// R18: Host writes threshold with line control not 0xbf and modem bit 6 set.
// R19: Ready bits one per channel, lowest bit of each nibble is channel one.
package ufc_pkg;
  localparam logic [2:0] ADDR_DIV_LOW    = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH   = 3'h1;
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_FIFO_CTRL  = 3'h2;
  localparam logic [2:0] ADDR_FEATURE    = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL  = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_THRESHOLD  = 3'h6;
  localparam logic [2:0] ADDR_TRIGGER    = 3'h7;
  localparam logic [2:0] ADDR_STOP_CHAR2 = 3'h7;
  localparam logic [2:0] ADDR_FIFO_READY = 3'h7;
  localparam logic [7:0] LCR_FEATURE_KEY = 8'hbf;
  localparam int LCR_DIV_ACCESS_BIT = 7;
  localparam int EFR_CTS_BIT        = 7;
  localparam int EFR_RTS_BIT        = 6;
  localparam int EFR_SPECIAL_BIT    = 5;
  localparam int EFR_WR_ENABLE_BIT  = 4;
  localparam int IER_SLEEP_BIT      = 4;
  localparam int MCR_TRIG_ACC_BIT   = 6;
  localparam int MCR_LOOPBACK_BIT   = 4;
  localparam int MCR_READY_EN_BIT   = 2;
  localparam int MCR_RTS_BIT        = 1;
  localparam int FCR_ENABLE_BIT     = 0;
  localparam logic [7:0] IER_PROT_MASK = 8'hf0;
  localparam logic [7:0] FCR_PROT_MASK = 8'h30;
  localparam logic [7:0] MCR_PROT_MASK = 8'he0;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [7:0] LCR_RESET     = 8'h1d;
  localparam logic [7:0] IIR_NONE      = 8'h01;
  localparam logic [7:0] IIR_SPECIAL   = 8'h10;
  // Fallback trigger levels chosen by the FIFO control bits, in bytes
  localparam logic [6:0] FCR_RX_LEVEL0 = 7'h08;
  localparam logic [6:0] FCR_RX_LEVEL1 = 7'h10;
  localparam logic [6:0] FCR_RX_LEVEL2 = 7'h38;
  localparam logic [6:0] FCR_RX_LEVEL3 = 7'h3c;
  localparam logic [6:0] FCR_TX_LEVEL0 = 7'h08;
  localparam logic [6:0] FCR_TX_LEVEL1 = 7'h10;
  localparam logic [6:0] FCR_TX_LEVEL2 = 7'h20;
  localparam logic [6:0] FCR_TX_LEVEL3 = 7'h38;
  localparam int CHANNELS  = 4;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [3:0] chanSelN;
    logic [2:0] addr;
    logic       wrN;
    logic       rdN;
    logic [7:0] data;
  } ufc_bus_t;

  typedef struct packed {
    logic [6:0] rxTrig;
    logic [6:0] txTrig;
  } ufc_trig_t;
endpackage

/* File: ufc_flow_trigger_config.sv */
// Module: register file, flow control and FIFO ready status of one UART channel
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_trigger_config (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Host register bus
  input  wire ufc_pkg::ufc_bus_t busReq,
  output var  logic [7:0]        dataOut,
  output var  logic              dataOutEnN,
  // Modem pins
  input  wire logic              ctsPin,
  output var  logic              rtsPin,
  // Channel FIFO state
  input  wire logic [6:0]        rxFill,
  input  wire logic [6:0]        txSpace,
  input  wire logic              rxTimeout,
  input  wire logic [2:0]        otherRxReady,
  input  wire logic [2:0]        otherTxReady,
  // Received characters towards the receive FIFO
  input  wire logic              rxCharValid,
  input  wire logic [7:0]        rxChar,
  output var  logic              rxCharReady,
  output var  logic              fifoWrValid,
  output var  logic [7:0]        fifoWrData,
  input  wire logic              fifoWrReady,
  // Configuration towards the datapath
  output var  logic              txHalt,
  output var  logic [3:0]        swFlowMode,
  output var  logic [15:0]       baudDivisor,
  output var  logic              sleepMode,
  output var  logic              specialCharFlag,
  output var  ufc_pkg::ufc_trig_t trigLevels
);

  function automatic logic [7:0] protWrite(input logic [7:0] oldVal, input logic [7:0] newVal,
                                           input logic [7:0] mask, input logic allow);
    protWrite = allow ? newVal : ((oldVal & mask) | (newVal & ~mask));
  endfunction

  function automatic logic [6:0] nibBytes(input logic [3:0] nib);
    nibBytes = {1'b0, nib, 2'b00};
  endfunction

  // Register state
  logic [7:0]  lcr_reg, lcr_next;
  logic [7:0]  ier_reg, ier_next;
  logic [7:0]  fcr_reg, fcr_next;
  logic [7:0]  mcr_reg, mcr_next;
  logic [7:0]  efr_reg, efr_next;
  logic [7:0]  dll_reg, dll_next;
  logic [7:0]  dlh_reg, dlh_next;
  logic [7:0]  tcr_reg, tcr_next;
  logic [7:0]  tlr_reg, tlr_next;
  logic [7:0]  stop2_reg, stop2_next;
  logic        wrPrev_reg, wrPrev_next;
  logic        rdPrev_reg, rdPrev_next;
  logic        special_reg, special_next;
  logic [7:0]  dout_reg, dout_next;
  logic        doutEnN_reg, doutEnN_next;

  // Flow and status outputs
  logic        rts_reg, rts_next;
  logic        txHalt_reg, txHalt_next;
  logic [3:0]  swFlow_reg, swFlow_next;
  logic [15:0] div_reg, div_next;
  logic        sleep_reg, sleep_next;
  ufc_pkg::ufc_trig_t trig_reg, trig_next;

  // Two-entry character buffer
  logic [7:0]  bufMem_reg [ufc_pkg::BUF_DEPTH];
  logic [7:0]  bufMem_next [ufc_pkg::BUF_DEPTH];
  logic        wrPtr_reg, wrPtr_next;
  logic        rdPtr_reg, rdPtr_next;
  logic [1:0]  count_reg, count_next;
  logic        inReady_reg, inReady_next;
  logic        outValid_reg, outValid_next;
  logic [7:0]  outData_reg, outData_next;

  logic        ownSel;
  logic        anySel;
  logic        featBank;
  logic        divBank;
  logic        trigAccess;
  logic        readyAccess;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        rdActive;
  logic [6:0]  rxTrigEff;
  logic [6:0]  txTrigEff;
  logic        ownRxReady;
  logic        ownTxReady;
  logic [7:0]  readyByte;
  logic        pushChar;
  logic        popChar;

  always_comb begin
    ownSel      = ~busReq.chanSelN[0];
    anySel      = ~(&busReq.chanSelN);
    featBank    = (lcr_reg == ufc_pkg::LCR_FEATURE_KEY);
    divBank     = lcr_reg[ufc_pkg::LCR_DIV_ACCESS_BIT] & ~featBank;
    trigAccess  = efr_reg[ufc_pkg::EFR_WR_ENABLE_BIT] & mcr_reg[ufc_pkg::MCR_TRIG_ACC_BIT]
                  & ~featBank & ~divBank;
    readyAccess = mcr_reg[ufc_pkg::MCR_READY_EN_BIT] & ~mcr_reg[ufc_pkg::MCR_LOOPBACK_BIT]
                  & (busReq.addr == ufc_pkg::ADDR_FIFO_READY); // R16
    wrStrobe    = ownSel & ~busReq.wrN & wrPrev_reg;
    rdActive    = ~busReq.rdN & (ownSel | (anySel & readyAccess));
    rdStrobe    = ownSel & ~busReq.rdN & rdPrev_reg;
    // Zero nibble defers to the FIFO control selection
    if (tlr_reg[7:4] != 4'h0) begin // R13
      rxTrigEff = nibBytes(tlr_reg[7:4]); // R11
    end else begin
      case (fcr_reg[7:6])
        2'h0:    rxTrigEff = ufc_pkg::FCR_RX_LEVEL0;
        2'h1:    rxTrigEff = ufc_pkg::FCR_RX_LEVEL1;
        2'h2:    rxTrigEff = ufc_pkg::FCR_RX_LEVEL2;
        default: rxTrigEff = ufc_pkg::FCR_RX_LEVEL3;
      endcase
    end
    if (tlr_reg[3:0] != 4'h0) begin // R13
      txTrigEff = nibBytes(tlr_reg[3:0]); // R11
    end else begin
      case (fcr_reg[5:4])
        2'h0:    txTrigEff = ufc_pkg::FCR_TX_LEVEL0;
        2'h1:    txTrigEff = ufc_pkg::FCR_TX_LEVEL1;
        2'h2:    txTrigEff = ufc_pkg::FCR_TX_LEVEL2;
        default: txTrigEff = ufc_pkg::FCR_TX_LEVEL3;
      endcase
    end
    ownRxReady = (rxFill > rxTrigEff) | rxTimeout; // R14
    ownTxReady = (txSpace >= txTrigEff); // R15
    readyByte  = {otherRxReady, ownRxReady, otherTxReady, ownTxReady}; // R19
    pushChar   = rxCharValid & inReady_reg;
    popChar    = outValid_reg & fifoWrReady;
  end

  // Register writes
  always_comb begin
    lcr_next   = lcr_reg;
    ier_next   = ier_reg;
    fcr_next   = fcr_reg;
    mcr_next   = mcr_reg;
    efr_next   = efr_reg;
    dll_next   = dll_reg;
    dlh_next   = dlh_reg;
    tcr_next   = tcr_reg;
    tlr_next   = tlr_reg;
    stop2_next = stop2_reg;
    if (wrStrobe) begin
      if (busReq.addr == ufc_pkg::ADDR_LINE_CTRL) begin
        lcr_next = busReq.data;
      end else if (featBank && busReq.addr == ufc_pkg::ADDR_FEATURE) begin
        efr_next = busReq.data; // R17
      end else if (featBank && busReq.addr == ufc_pkg::ADDR_STOP_CHAR2) begin
        stop2_next = busReq.data;
      end else if (divBank && busReq.addr == ufc_pkg::ADDR_DIV_LOW) begin
        if (!ier_reg[ufc_pkg::IER_SLEEP_BIT]) begin // R7
          dll_next = busReq.data;
        end
      end else if (divBank && busReq.addr == ufc_pkg::ADDR_DIV_HIGH) begin
        if (!ier_reg[ufc_pkg::IER_SLEEP_BIT]) begin // R7
          dlh_next = busReq.data;
        end
      end else if (busReq.addr == ufc_pkg::ADDR_INT_ENABLE) begin
        ier_next = protWrite(ier_reg, busReq.data, ufc_pkg::IER_PROT_MASK,
                             efr_reg[ufc_pkg::EFR_WR_ENABLE_BIT]); // R4
      end else if (busReq.addr == ufc_pkg::ADDR_FIFO_CTRL) begin
        fcr_next = protWrite(fcr_reg, busReq.data, ufc_pkg::FCR_PROT_MASK,
                             efr_reg[ufc_pkg::EFR_WR_ENABLE_BIT]); // R4
      end else if (busReq.addr == ufc_pkg::ADDR_MODEM_CTRL) begin
        mcr_next = protWrite(mcr_reg, busReq.data, ufc_pkg::MCR_PROT_MASK,
                             efr_reg[ufc_pkg::EFR_WR_ENABLE_BIT]); // R4
      end else if (trigAccess && busReq.addr == ufc_pkg::ADDR_THRESHOLD) begin
        tcr_next = busReq.data; // R9
      end else if (trigAccess && busReq.addr == ufc_pkg::ADDR_TRIGGER) begin
        tlr_next = busReq.data; // R12
      end
    end
  end

  // Read data latched on the strobe's first edge; a clear-on-read cannot alter it mid-strobe
  always_comb begin
    wrPrev_next  = busReq.wrN;
    rdPrev_next  = busReq.rdN;
    doutEnN_next = ~rdActive;
    dout_next    = dout_reg;
    if (rdActive && rdPrev_reg) begin
      if (readyAccess) begin
        dout_next = readyByte; // R16
      end else if (busReq.addr == ufc_pkg::ADDR_LINE_CTRL) begin
        dout_next = lcr_reg;
      end else if (featBank && busReq.addr == ufc_pkg::ADDR_FEATURE) begin
        dout_next = efr_reg;
      end else if (featBank && busReq.addr == ufc_pkg::ADDR_STOP_CHAR2) begin
        dout_next = stop2_reg;
      end else if (divBank && busReq.addr == ufc_pkg::ADDR_DIV_LOW) begin
        dout_next = dll_reg;
      end else if (divBank && busReq.addr == ufc_pkg::ADDR_DIV_HIGH) begin
        dout_next = dlh_reg;
      end else if (busReq.addr == ufc_pkg::ADDR_INT_ENABLE) begin
        dout_next = ier_reg;
      end else if (busReq.addr == ufc_pkg::ADDR_FIFO_CTRL) begin
        // Identification: FIFO enable mirrored in the top bits
        dout_next = special_reg ? ufc_pkg::IIR_SPECIAL : ufc_pkg::IIR_NONE;
        dout_next[7] = fcr_reg[ufc_pkg::FCR_ENABLE_BIT];
        dout_next[6] = fcr_reg[ufc_pkg::FCR_ENABLE_BIT];
      end else if (busReq.addr == ufc_pkg::ADDR_MODEM_CTRL) begin
        dout_next = mcr_reg;
      end else if (trigAccess && busReq.addr == ufc_pkg::ADDR_THRESHOLD) begin
        dout_next = tcr_reg;
      end else if (trigAccess && busReq.addr == ufc_pkg::ADDR_TRIGGER) begin
        dout_next = tlr_reg;
      end else begin
        dout_next = ufc_pkg::RESET_BYTE;
      end
    end
    special_next = special_reg;
    // Reading the identification clears the flag; a match in the same cycle wins
    if (rdStrobe && !featBank && !divBank && busReq.addr == ufc_pkg::ADDR_FIFO_CTRL) begin
      special_next = 1'b0;
    end
    if (pushChar && efr_reg[ufc_pkg::EFR_SPECIAL_BIT] && rxChar == stop2_reg) begin
      special_next = 1'b1; // R3
    end
  end

  // Flow control and configuration outputs
  always_comb begin
    rts_next = rts_reg;
    if (efr_reg[ufc_pkg::EFR_RTS_BIT]) begin
      // Halt level above resume level is the host's job; no check here
      if (rxFill >= nibBytes(tcr_reg[3:0])) begin // R2 R8 R10
        rts_next = 1'b1;
      end else if (rxFill <= nibBytes(tcr_reg[7:4])) begin // R2 R8
        rts_next = 1'b0;
      end
    end else begin
      rts_next = ~mcr_reg[ufc_pkg::MCR_RTS_BIT];
    end
    txHalt_next = efr_reg[ufc_pkg::EFR_CTS_BIT] & ctsPin; // R1
    swFlow_next = efr_reg[3:0]; // R5
    div_next    = {dlh_reg, dll_reg}; // R6
    sleep_next  = ier_reg[ufc_pkg::IER_SLEEP_BIT];
    trig_next   = '{rxTrig: rxTrigEff, txTrig: txTrigEff};
  end

  // Character buffer: ready is registered, so a word arriving while full waits
  always_comb begin
    bufMem_next = bufMem_reg;
    wrPtr_next  = wrPtr_reg;
    rdPtr_next  = rdPtr_reg;
    count_next  = count_reg;
    if (pushChar) begin
      bufMem_next[wrPtr_reg] = rxChar; // R3
      wrPtr_next = ~wrPtr_reg;
    end
    if (popChar) begin
      rdPtr_next = ~rdPtr_reg;
    end
    if (pushChar && !popChar) begin
      count_next = count_reg + 2'h1;
    end else if (popChar && !pushChar) begin
      count_next = count_reg - 2'h1;
    end
    inReady_next  = (count_next != 2'(ufc_pkg::BUF_DEPTH));
    outValid_next = (count_next != 2'h0);
    outData_next  = bufMem_next[rdPtr_next];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lcr_reg      <= ufc_pkg::LCR_RESET;
      ier_reg      <= ufc_pkg::RESET_BYTE;
      fcr_reg      <= ufc_pkg::RESET_BYTE;
      mcr_reg      <= ufc_pkg::RESET_BYTE;
      efr_reg      <= ufc_pkg::RESET_BYTE;
      dll_reg      <= ufc_pkg::RESET_BYTE;
      dlh_reg      <= ufc_pkg::RESET_BYTE;
      tcr_reg      <= ufc_pkg::RESET_BYTE;
      tlr_reg      <= ufc_pkg::RESET_BYTE;
      stop2_reg    <= ufc_pkg::RESET_BYTE;
      wrPrev_reg   <= 1'b1;
      rdPrev_reg   <= 1'b1;
      special_reg  <= 1'b0;
      dout_reg     <= ufc_pkg::RESET_BYTE;
      doutEnN_reg  <= 1'b1;
      rts_reg      <= 1'b1;
      txHalt_reg   <= 1'b0;
      swFlow_reg   <= 4'h0;
      div_reg      <= 16'h0000;
      sleep_reg    <= 1'b0;
      trig_reg     <= '0;
      bufMem_reg   <= '{default: 8'h00};
      wrPtr_reg    <= 1'b0;
      rdPtr_reg    <= 1'b0;
      count_reg    <= 2'h0;
      inReady_reg  <= 1'b1;
      outValid_reg <= 1'b0;
      outData_reg  <= 8'h00;
    end else begin
      lcr_reg      <= lcr_next;
      ier_reg      <= ier_next;
      fcr_reg      <= fcr_next;
      mcr_reg      <= mcr_next;
      efr_reg      <= efr_next;
      dll_reg      <= dll_next;
      dlh_reg      <= dlh_next;
      tcr_reg      <= tcr_next;
      tlr_reg      <= tlr_next;
      stop2_reg    <= stop2_next;
      wrPrev_reg   <= wrPrev_next;
      rdPrev_reg   <= rdPrev_next;
      special_reg  <= special_next;
      dout_reg     <= dout_next;
      doutEnN_reg  <= doutEnN_next;
      rts_reg      <= rts_next;
      txHalt_reg   <= txHalt_next;
      swFlow_reg   <= swFlow_next;
      div_reg      <= div_next;
      sleep_reg    <= sleep_next;
      trig_reg     <= trig_next;
      bufMem_reg   <= bufMem_next;
      wrPtr_reg    <= wrPtr_next;
      rdPtr_reg    <= rdPtr_next;
      count_reg    <= count_next;
      inReady_reg  <= inReady_next;
      outValid_reg <= outValid_next;
      outData_reg  <= outData_next;
    end
  end

  assign dataOut         = dout_reg;
  assign dataOutEnN      = doutEnN_reg;
  assign rtsPin          = rts_reg;
  assign txHalt          = txHalt_reg;
  assign swFlowMode      = swFlow_reg;
  assign baudDivisor     = div_reg;
  assign sleepMode       = sleep_reg;
  assign specialCharFlag = special_reg;
  assign trigLevels      = trig_reg;
  assign rxCharReady     = inReady_reg;
  assign fifoWrValid     = outValid_reg;
  assign fifoWrData      = outData_reg;

endmodule
`default_nettype wire

/* File: ufc_fifo_sink.sv */
// Receive FIFO model that takes buffered characters and can stall
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo_sink (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Character stream
  input  wire logic       fifoWrValid,
  input  wire logic [7:0] fifoWrData,
  output var  logic       fifoWrReady,
  // Test control
  input  wire logic       stall
);
  logic [7:0] got [$];

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fifoWrReady <= 1'b0;
    end else begin
      if (fifoWrValid && fifoWrReady) got.push_back(fifoWrData);
      fifoWrReady <= !stall;
    end
  end
endmodule
`default_nettype wire

/* File: ufc_checker.sv */
// Checker: port-level properties of the flow and trigger configuration block
`timescale 1ns/1ps
`default_nettype none
module ufc_checker (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  // Bus and pins
  input wire ufc_pkg::ufc_bus_t  busReq,
  input wire logic               dataOutEnN,
  input wire logic               ctsPin,
  input wire logic               txHalt,
  // Character path
  input wire logic               rxCharValid,
  input wire logic [7:0]         rxChar,
  input wire logic               rxCharReady,
  input wire logic               fifoWrValid,
  input wire logic [7:0]         fifoWrData,
  input wire logic               fifoWrReady,
  // Configuration
  input wire logic [3:0]         swFlowMode,
  input wire logic [15:0]        baudDivisor,
  input wire logic               sleepMode,
  input wire ufc_pkg::ufc_trig_t trigLevels
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_halt_needs_cts: assert property (txHalt |-> $past(ctsPin))
    else $error("halt without CTS high");
  a_flow_by_write: assert property (!$stable(swFlowMode) |-> !$past(busReq.wrN, 2))
    else $error("flow mode changed without write");
  a_div_one_byte: assert property (!$stable(baudDivisor) |->
    baudDivisor[15:8] == $past(baudDivisor[15:8]) || baudDivisor[7:0] == $past(baudDivisor[7:0]))
    else $error("divisor bytes changed together");
  a_sleep_div_hold: assert property (sleepMode && $past(sleepMode) |-> $stable(baudDivisor))
    else $error("divisor changed in sleep");
  a_trig_steps: assert property (trigLevels.rxTrig[1:0] == 2'h0 && trigLevels.txTrig[1:0] == 2'h0)
    else $error("trigger not a multiple of four");
  a_trig_nonzero: assert property ($past(nrst) |-> trigLevels.rxTrig != 7'h00 &&
    trigLevels.txTrig != 7'h00)
    else $error("zero trigger level in use");
  a_read_drive: assert property (!busReq.rdN && !busReq.chanSelN[0] |=> !dataOutEnN)
    else $error("read not driven");
  a_idle_release: assert property (busReq.rdN |=> dataOutEnN)
    else $error("data driven while idle");
  a_char_pass: assert property (rxCharValid && rxCharReady && !fifoWrValid |=>
    fifoWrValid && fifoWrData == $past(rxChar))
    else $error("character not passed on");
  a_out_hold: assert property (fifoWrValid && !fifoWrReady |=> fifoWrValid && $stable(fifoWrData))
    else $error("stalled character lost");
  a_full_valid: assert property (!rxCharReady |-> fifoWrValid)
    else $error("refusing while empty");
endmodule
bind ufc_flow_trigger_config ufc_checker chk_u (.sys_clk(sys_clk), .nrst(nrst), .busReq(busReq),
  .dataOutEnN(dataOutEnN), .ctsPin(ctsPin), .txHalt(txHalt), .rxCharValid(rxCharValid),
  .rxChar(rxChar), .rxCharReady(rxCharReady), .fifoWrValid(fifoWrValid),
  .fifoWrData(fifoWrData), .fifoWrReady(fifoWrReady), .swFlowMode(swFlowMode),
  .baudDivisor(baudDivisor), .sleepMode(sleepMode), .trigLevels(trigLevels));
`default_nettype wire

/* File: tb_top.sv */
// Testbench: host access, flow control, character buffer and ready status
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [6:0] FILLS [5]   = '{7'h20, 7'h14, 7'h10, 7'h1f, 7'h20};
  localparam logic       RTS_EXP [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic [7:0] CHARS [3]   = '{8'h13, 8'h41, 8'h42};
  logic               sys_clk = 1'b0;
  logic               nrst = 1'b0;
  ufc_pkg::ufc_bus_t  busReq = '{4'hf, 3'h0, 1'b1, 1'b1, 8'h00};
  logic               ctsPin = 1'b0;
  logic [6:0]         rxFill = 7'h00;
  logic [6:0]         txSpace = 7'h00;
  logic               rxTimeout = 1'b0;
  logic [2:0]         otherRxReady = 3'h5;
  logic [2:0]         otherTxReady = 3'h2;
  logic               rxCharValid = 1'b0;
  logic [7:0]         rxChar = 8'h00;
  logic               stall = 1'b1;
  logic [7:0]         dataOut;
  logic [7:0]         fifoWrData;
  logic [15:0]        baudDivisor;
  logic [3:0]         swFlowMode;
  logic               dataOutEnN, rtsPin, rxCharReady, fifoWrValid, fifoWrReady;
  logic               txHalt, sleepMode, specialCharFlag;
  ufc_pkg::ufc_trig_t trigLevels;
  int                 errTotal = 0;
  int                 testsRun = 0;

  always #50 sys_clk = ~sys_clk;

  ufc_flow_trigger_config dut_u (.sys_clk, .nrst, .busReq, .dataOut, .dataOutEnN, .ctsPin,
    .rtsPin, .rxFill, .txSpace, .rxTimeout, .otherRxReady, .otherTxReady, .rxCharValid,
    .rxChar, .rxCharReady, .fifoWrValid, .fifoWrData, .fifoWrReady, .txHalt, .swFlowMode,
    .baudDivisor, .sleepMode, .specialCharFlag, .trigLevels);
  ufc_fifo_sink sink_u (.sys_clk, .nrst, .fifoWrValid, .fifoWrData, .fifoWrReady, .stall);

  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ends just after an edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Strobe must be seen high again before the next write counts
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{4'he, a, 1'b0, 1'b1, d};
    @(posedge sys_clk);
    busReq <= '{4'hf, a, 1'b1, 1'b1, d};
    tick(2);
  endtask

  task automatic rd(input logic [3:0] cs, input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{cs, a, 1'b1, 1'b0, 8'h00};
    tick(2);
    d = dataOut;
    @(posedge sys_clk);
    busReq <= '{4'hf, a, 1'b1, 1'b1, 8'h00};
    tick(1);
  endtask

  task automatic sendc(input logic [7:0] c);
    @(posedge sys_clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    do @(negedge sys_clk); while (rxCharReady !== 1'b1);
    @(posedge sys_clk);
    rxCharValid <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    errTotal++;
    testDone();
  end

  initial begin
    logic [7:0] v;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(2);
    chk("rts", rtsPin, 1'b1);
    chk("trig", trigLevels, {7'h08, 7'h08});
    rd(4'he, 3'h3, v);
    chk("lcr", v, 8'h1d);
    wr(3'h1, 8'hf0);
    chk("sleep", sleepMode, 1'b0);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk("div", baudDivisor, 16'h1234);
    $display("test reset and divisor done");
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'hb0);
    wr(3'h7, 8'h13);
    chk("swflow", swFlowMode, 4'h0);
    @(posedge sys_clk) ctsPin <= 1'b1;
    tick(2);
    chk("halt", txHalt, 1'b1);
    @(posedge sys_clk) ctsPin <= 1'b0;
    tick(2);
    chk("halt", txHalt, 1'b0);
    wr(3'h3, 8'h00);
    wr(3'h7, 8'h34);
    chk("trig", trigLevels, {7'h08, 7'h08});
    wr(3'h4, 8'h44);
    wr(3'h6, 8'h48);
    wr(3'h7, 8'h34);
    chk("trig", trigLevels, {7'h0c, 7'h10});
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'hf5);
    wr(3'h3, 8'h00);
    chk("swflow", swFlowMode, 4'h5);
    foreach (FILLS[i]) begin
      @(posedge sys_clk) rxFill <= FILLS[i];
      tick(2);
      chk("rts", rtsPin, RTS_EXP[i]);
    end
    $display("test flow control done");
    @(posedge sys_clk) txSpace <= 7'h0f;
    rd(4'hd, 3'h7, v);
    chk("ready", v, 8'hb4);
    @(posedge sys_clk) txSpace <= 7'h10;
    rxFill <= 7'h0c;
    rd(4'he, 3'h7, v);
    chk("ready", v, 8'ha5);
    @(posedge sys_clk) rxTimeout <= 1'b1;
    rd(4'h7, 3'h7, v);
    chk("ready", v, 8'hb5);
    wr(3'h7, 8'h30);
    chk("trig", trigLevels, {7'h0c, 7'h08});
    wr(3'h7, 8'h05);
    chk("trig", trigLevels, {7'h08, 7'h14});
    wr(3'h2, 8'hc1);
    chk("trig", trigLevels, {7'h3c, 7'h14});
    $display("test ready and trigger done");
    sendc(CHARS[0]);
    sendc(CHARS[1]);
    tick(2);
    chk("full", rxCharReady, 1'b0);
    chk("special", specialCharFlag, 1'b1);
    rd(4'he, 3'h2, v);
    chk("ident", v, 8'hd0);
    chk("special", specialCharFlag, 1'b0);
    @(posedge sys_clk) stall <= 1'b0;
    sendc(CHARS[2]);
    tick(6);
    foreach (CHARS[i]) chk("char", sink_u.got[i], CHARS[i]);
    wr(3'h1, 8'h10);
    chk("sleep", sleepMode, 1'b1);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h77);
    chk("div", baudDivisor, 16'h1234);
    $display("test buffer and sleep done");
    testDone();
  end
endmodule
`default_nettype wire
